/* tef_flag.sv */
/*
 * One event flag with its own clear-arming state.
 * Assumes the caller delivers single-cycle pulses on the same clock.
 */
`timescale 1ns/1ps
module tef_flag (
	input wire logic clock,
	input wire logic rstn,
	input tef_pkg::tef_flagreq_type req,
	output logic flag
);
	logic flag_ff;
	logic armed_ff;
	logic nxt_flag;
	logic nxt_armed;
	// ==========================================================
	// Arm on a read of a set flag; a fresh event disarms so the write cannot lose it.
	assign nxt_armed = req.setEvt ? 1'b0 : (req.readSeen && flag_ff) ? 1'b1 :
		req.writeZero ? 1'b0 : armed_ff;
	// Set always wins; zero write clears only when armed; writing one does nothing.
	assign nxt_flag = req.setEvt ? 1'b1 : (req.writeZero && armed_ff) ? 1'b0 : flag_ff;
	// Flag and arm registers.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			flag_ff <= 1'b0;
			armed_ff <= 1'b0;
		end else begin
			flag_ff <= nxt_flag;
			armed_ff <= nxt_armed;
		end
	end
	assign flag = flag_ff;
	// ==========================================================
	// Checks.
	a_clear_needs_arm: assert property (@(posedge clock) disable iff (!rstn)
		$fell(flag_ff) |-> $past(armed_ff) && $past(req.writeZero))
		else $error("Flag cleared without armed zero write.");
	a_event_wins_clear: assert property (@(posedge clock) disable iff (!rstn)
		req.setEvt |=> flag_ff && !armed_ff)
		else $error("Fresh event lost or left clear armed.");
	a_unarmed_write_keeps: assert property (@(posedge clock) disable iff (!rstn)
		flag_ff && req.writeZero && !armed_ff |=> flag_ff)
		else $error("Unarmed zero write cleared the flag.");
	c_flag_cleared: cover property (@(posedge clock) disable iff (!rstn)
		flag_ff ##1 armed_ff ##[1:8] !flag_ff);
endmodule

/* tef_pkg.sv */
/*
 * Package for the timer event-flag block: register map, field positions,
 * reset values, channel modes and packed carrier types.
 * Assumes a 32-bit APB slave with byte addresses and one word per register.
 */
package tef_pkg;
	// ==========================================================
	// Register map
	localparam logic [11:0] ADDR_CTRL = 12'h000;
	localparam logic [11:0] ADDR_MOD = 12'h004;
	localparam logic [11:0] ADDR_STAT = 12'h008;
	localparam logic [11:0] ADDR_MASK = 12'h00C;
	localparam logic [11:0] ADDR_CNT = 12'h010;
	localparam logic [11:0] ADDR_CHCFG = 12'h020;
	localparam logic [11:0] ADDR_CHVAL = 12'h040;
	// ==========================================================
	// Field positions and reset values
	localparam int CTRL_RUN_BIT = 0;
	localparam int CTRL_CALIGN_BIT = 1;
	localparam int CTRL_WRAPIE_BIT = 2;
	localparam int STAT_WRAP_BIT = 0;
	localparam int STAT_CH_LSB = 1;
	localparam logic [15:0] MOD_RESET = 16'h0000;
	localparam logic [15:0] CNT_ZERO = 16'h0000;
	localparam logic [15:0] CNT_FULL = 16'hFFFF;
	localparam logic [31:0] RD_ZERO = 32'h0000_0000;
	// ==========================================================
	// Channel modes
	typedef enum logic [1:0] {
		MODE_CAPTURE = 2'b00,
		MODE_COMPARE = 2'b01,
		MODE_EDGE_PWM = 2'b10
	} tef_chmode_type;
	// Channel configuration word: mode, edge select and interrupt enable.
	typedef struct packed {
		logic channelIrqEnable;
		logic edgeSelHigh;
		logic edgeSelLow;
		tef_chmode_type mode;
	} tef_chcfg_type;
	// Flag event request set: one set pulse, one clear-arming read, one zero write.
	typedef struct packed {
		logic setEvt;
		logic readSeen;
		logic writeZero;
	} tef_flagreq_type;
endpackage

/* tef_timer_flags.sv */
/*
 * Event-flag logic of a 16-bit timer with PWM channels, behind an APB slave.
 * Holds a small counter to create wrap events, per-channel capture and match
 * detection, sticky flags with two-step clearing and one level interrupt.
 * Assumes capture inputs come from pins and are asynchronous.
 */
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module tef_timer_flags #(
	parameter int NUM_CH = 2
) (
	input wire logic clock,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [NUM_CH-1:0] captureIn,
	output logic irq
);
	localparam int NF = NUM_CH + 1;
	// ==========================================================
	// Bus decode.
	logic [31:0] rdata_ff;
	logic pready_ff;
	logic pslverr_ff;
	logic setupPhase;
	logic [NUM_CH-1:0] selCfg;
	logic [NUM_CH-1:0] selVal;
	logic hitCtrl;
	logic hitMod;
	logic hitStat;
	logic hitMask;
	logic hitCnt;
	logic anyHit;
	logic doWrite;
	logic doRead;
	// Registers are answered in the access phase one cycle after setup.
	assign setupPhase = psel && !penable;
	assign doWrite = psel && penable && pwrite && anyHit;
	assign doRead = psel && penable && !pwrite && anyHit;
	assign hitCtrl = (paddr == tef_pkg::ADDR_CTRL);
	assign hitMod = (paddr == tef_pkg::ADDR_MOD);
	assign hitStat = (paddr == tef_pkg::ADDR_STAT);
	assign hitMask = (paddr == tef_pkg::ADDR_MASK);
	assign hitCnt = (paddr == tef_pkg::ADDR_CNT);
	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : gDec
			assign selCfg[g] = (paddr == tef_pkg::ADDR_CHCFG + 12'(4 * g));
			assign selVal[g] = (paddr == tef_pkg::ADDR_CHVAL + 12'(4 * g));
		end
	endgenerate
	assign anyHit = hitCtrl || hitMod || hitStat || hitMask || hitCnt || (|selCfg) || (|selVal);
	// ==========================================================
	// Software registers.
	logic run_ff;
	logic calign_ff;
	logic wrapIe_ff;
	logic [15:0] mod_ff;
	logic [NF-1:0] mask_ff;
	tef_pkg::tef_chcfg_type cfg_ff [NUM_CH];
	logic [15:0] val_ff [NUM_CH];
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			run_ff <= 1'b0;
			calign_ff <= 1'b0;
			wrapIe_ff <= 1'b0;
			mod_ff <= tef_pkg::MOD_RESET;
			mask_ff <= '0;
		end else if (doWrite) begin
			if (hitCtrl) begin
				run_ff <= pwdata[tef_pkg::CTRL_RUN_BIT];
				calign_ff <= pwdata[tef_pkg::CTRL_CALIGN_BIT];
				wrapIe_ff <= pwdata[tef_pkg::CTRL_WRAPIE_BIT];
			end else if (hitMod) begin
				mod_ff <= pwdata[15:0];
			end else if (hitMask) begin
				mask_ff <= pwdata[NF-1:0];
			end
		end
	end
	// Channel configuration and compare values.
	generate
		for (g = 0; g < NUM_CH; g++) begin : gChReg
			always_ff @(posedge clock or negedge rstn) begin
				if (!rstn) begin
					cfg_ff[g] <= '0;
					val_ff[g] <= tef_pkg::CNT_ZERO;
				end else if (doWrite && selCfg[g]) begin
					cfg_ff[g] <= pwdata[4:0];
				end else if (doWrite && selVal[g]) begin
					val_ff[g] <= pwdata[15:0];
				end
			end
		end
	endgenerate
	// ==========================================================
	// Counter, up or up/down.
	logic [15:0] cnt_ff;
	logic down_ff;
	logic [15:0] nxt_cnt;
	logic nxt_down;
	logic atTop;
	logic wrapEvt;
	// A zero modulus means the free-running full range.
	assign atTop = (mod_ff == tef_pkg::CNT_ZERO) ? (cnt_ff == tef_pkg::CNT_FULL) : (cnt_ff == mod_ff);
	// Up/down turns at the modulus and again at zero.
	assign nxt_down = calign_ff ? (atTop ? 1'b1 : (cnt_ff == 16'h0001 && down_ff) ? 1'b0 : down_ff)
		: 1'b0;
	assign nxt_cnt = !run_ff ? cnt_ff : calign_ff ? (down_ff && !atTop ? cnt_ff - 16'h0001 :
		atTop ? cnt_ff - 16'h0001 : cnt_ff + 16'h0001)
		: (atTop ? tef_pkg::CNT_ZERO : cnt_ff + 16'h0001);
	// Wrap: up mode at top-to-zero, up/down at the turn downward.
	assign wrapEvt = run_ff && atTop;
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			cnt_ff <= tef_pkg::CNT_ZERO;
			down_ff <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			down_ff <= run_ff ? nxt_down : down_ff;
		end
	end
	// ==========================================================
	// Channel events.
	logic [NUM_CH-1:0] capMeta_ff;
	logic [NUM_CH-1:0] capSync_ff;
	logic [NUM_CH-1:0] capLast_ff;
	logic [NUM_CH-1:0] chEvt;
	// Two-stage synchroniser, then an edge detector on the second stage only.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			capMeta_ff <= '0;
			capSync_ff <= '0;
			capLast_ff <= '0;
		end else begin
			capMeta_ff <= captureIn;
			capSync_ff <= capMeta_ff;
			capLast_ff <= capSync_ff;
		end
	end
	generate
		for (g = 0; g < NUM_CH; g++) begin : gEvt
			logic rise;
			logic fall;
			logic match;
			assign rise = capSync_ff[g] && !capLast_ff[g];
			assign fall = !capSync_ff[g] && capLast_ff[g];
			// Matches only count while the counter runs, so a stopped timer is silent.
			assign match = run_ff && (cnt_ff == val_ff[g]);
			// Center PWM is every channel, capture mode included, while center-align is set; both
			// the up and the down match flag the channel.
			assign chEvt[g] = (cfg_ff[g].mode == tef_pkg::MODE_CAPTURE && !calign_ff) ?
				((cfg_ff[g].edgeSelLow && rise) || (cfg_ff[g].edgeSelHigh && fall))
				: match;
		end
	endgenerate
	// ==========================================================
	// Flags: bit 0 is the wrap flag, bits above are channel flags.
	logic [NF-1:0] flags;
	logic [NF-1:0] setVec;
	logic [NF-1:0] ieVec;
	logic statRead;
	logic statWrite;
	assign setVec = {chEvt, wrapEvt};
	assign statRead = doRead && hitStat;
	assign statWrite = doWrite && hitStat;
	generate
		for (g = 0; g < NF; g++) begin : gFlag
			tef_pkg::tef_flagreq_type rq;
			assign rq.setEvt = setVec[g];
			assign rq.readSeen = statRead;
			assign rq.writeZero = statWrite && !pwdata[g];
			tef_flag uFlag (
				.clock(clock),
				.rstn(rstn),
				.req(rq),
				.flag(flags[g])
			);
			if (g == 0) begin : gIe0
				assign ieVec[g] = wrapIe_ff;
			end else begin : gIeN
				assign ieVec[g] = cfg_ff[g-1].channelIrqEnable;
			end
		end
	endgenerate
	// ==========================================================
	// Read mux and answer registers; unmapped addresses return an error.
	logic [31:0] rdMux;
	logic irq_ff;
	logic [31:0] cfgRd;
	logic [31:0] valRd;
	always_comb begin
		cfgRd = tef_pkg::RD_ZERO;
		valRd = tef_pkg::RD_ZERO;
		for (int i = 0; i < NUM_CH; i++) begin
			if (selCfg[i]) begin
				cfgRd = {27'h000_0000, cfg_ff[i]};
			end
			if (selVal[i]) begin
				valRd = {16'h0000, val_ff[i]};
			end
		end
	end
	assign rdMux = hitCtrl ? {29'h0000_0000, wrapIe_ff, calign_ff, run_ff} :
		hitMod ? {16'h0000, mod_ff} :
		hitStat ? 32'(flags) :
		hitMask ? 32'(mask_ff) :
		hitCnt ? {16'h0000, cnt_ff} : (cfgRd | valRd);
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rdata_ff <= tef_pkg::RD_ZERO;
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			irq_ff <= 1'b0;
		end else begin
			rdata_ff <= setupPhase ? rdMux : rdata_ff;
			pready_ff <= setupPhase;
			pslverr_ff <= setupPhase && !anyHit;
			irq_ff <= |(flags & ieVec & ~mask_ff);
		end
	end
	assign prdata = rdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign irq = irq_ff;
	// ==========================================================
	// Checks.
	a_irq_follows_flag: assert property (@(posedge clock) disable iff (!rstn)
		##1 irq == $past(|(flags & ieVec & ~mask_ff)))
		else $error("Interrupt level does not follow flags.");
	a_free_wrap: assert property (@(posedge clock) disable iff (!rstn)
		run_ff && !calign_ff && mod_ff == 16'h0000 && cnt_ff == 16'hFFFF |=>
		cnt_ff == 16'h0000 && flags[0])
		else $error("Free wrap did not reach zero with flag.");
	a_mod_wrap: assert property (@(posedge clock) disable iff (!rstn)
		run_ff && !calign_ff && mod_ff != 16'h0000 && cnt_ff == mod_ff && !doWrite |=>
		cnt_ff == 16'h0000 && flags[0])
		else $error("Modulus wrap failed.");
	a_updown_turn: assert property (@(posedge clock) disable iff (!rstn)
		run_ff && calign_ff && mod_ff != 16'h0000 && cnt_ff == mod_ff && !doWrite |=>
		cnt_ff == $past(cnt_ff) - 16'h0001 && flags[0])
		else $error("Up/down turn at modulus failed.");
	a_match_sets: assert property (@(posedge clock) disable iff (!rstn)
		chEvt[0] |=> flags[1])
		else $error("Channel event did not set its flag.");
	a_rise_capture: assert property (@(posedge clock) disable iff (!rstn)
		!calign_ff && cfg_ff[0] == 5'b00100 && capSync_ff[0] && !capLast_ff[0] |=> flags[1])
		else $error("Rising capture edge missed.");
	a_ready_one: assert property (@(posedge clock) disable iff (!rstn)
		setupPhase |=> pready ##1 !pready || (psel && !penable))
		else $error("Ready not a one-cycle answer.");
	c_wrap_seen: cover property (@(posedge clock) disable iff (!rstn) wrapEvt);
	c_center_turn: cover property (@(posedge clock) disable iff (!rstn) calign_ff && down_ff);
	c_irq_raised: cover property (@(posedge clock) disable iff (!rstn) $rose(irq));
endmodule

/* timer_event_flag_logic_tb_top.sv */
/*
 * Self-checking bench for the timer event-flag block: register table rows,
 * then hand-written flag, clearing, interrupt and counting-mode cases.
 * Assumes the APB slave answers with pready and the package register map.
 */
`timescale 1ns/1ps
module timer_event_flag_logic_tb_top;
	typedef struct packed {
		logic [11:0] a;
		logic w;
		logic [31:0] d;
		logic e;
	} tef_row_type;
	localparam logic [11:0] ST = tef_pkg::ADDR_STAT;
	localparam logic [11:0] CT = tef_pkg::ADDR_CTRL;
	localparam logic [11:0] MD = tef_pkg::ADDR_MOD;
	localparam logic [11:0] CF = tef_pkg::ADDR_CHCFG;
	localparam logic [11:0] CV = tef_pkg::ADDR_CHVAL;
	localparam logic [11:0] MK = tef_pkg::ADDR_MASK;
	localparam logic [11:0] CN = tef_pkg::ADDR_CNT;
	logic clock, rstn, psel, penable, pwrite, pready, pslverr, irq, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [1:0] captureIn;
	int errorCnt = 0;
	int nTests = 0;
	int i, s;
	// Writes, read-backs, a read-only counter and an unmapped address.
	tef_row_type rows[10] = '{'{MD, 1'b1, 32'h1234, 1'b0}, '{MD, 1'b0, 32'h1234, 1'b0},
		'{MK, 1'b1, 32'h7, 1'b0}, '{MK, 1'b0, 32'h7, 1'b0},
		'{CV + 12'h004, 1'b1, 32'hBEEF, 1'b0}, '{CV + 12'h004, 1'b0, 32'hBEEF, 1'b0},
		'{CN, 1'b1, 32'hFF, 1'b0}, '{CN, 1'b0, 32'h0, 1'b0},
		'{12'h100, 1'b0, 32'h0, 1'b1}, '{MK, 1'b1, 32'h0, 1'b0}};

	tef_timer_flags #(.NUM_CH(2)) u_dut (.clock(clock), .rstn(rstn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .captureIn(captureIn),
		.irq(irq));

	// ==========================================================
	// Clock.
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	// ==========================================================
	// Shared tasks.
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", nTests, errorCnt);
		if (errorCnt == 0 && nTests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		nTests++;
		if (got !== exp) begin
			errorCnt++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One APB transfer; it starts on a fresh edge so no signal is assigned twice at once.
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		int k;
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		for (k = 0; k < 16; k++) begin
			@(posedge clock);
			if (pready === 1'b1) break;
		end
		if (k == 16) begin
			errorCnt++;
			complete_run();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
		apb(a, 1'b0, 32'h0);
		chk(rd, exp);
	endtask

	// Polls a status bit; a bound that runs out shows up as a mismatch.
	task automatic waitFlag(input int b, input int bound);
		int k;
		for (k = 0; k < bound; k++) begin
			apb(ST, 1'b0, 32'h0);
			if (rd[b] === 1'b1) break;
		end
		chk(32'(rd[b]), 32'h1);
	endtask

	// Two-step clear of the bits in m; other bits are written one and kept.
	task automatic clr(input logic [31:0] m);
		apb(ST, 1'b0, 32'h0);
		apb(ST, 1'b1, 32'h7 & ~m);
	endtask

	// Pin change, then time for the two-stage synchroniser and the flag.
	task automatic pin(input int c, input logic v);
		@(posedge clock);
		captureIn[c] <= v;
		repeat (6) @(posedge clock);
	endtask

	// ==========================================================
	// Main sequence.
	initial begin
		rstn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h0;
		pwdata = 32'h0;
		captureIn = 2'b00;
		repeat (4) @(posedge clock);
		rstn <= 1'b1;
		chk(32'(irq), 32'h0);
		rdchk(ST, 32'h0);
		rdchk(CT, 32'h0);
		rdchk(MD, 32'(tef_pkg::MOD_RESET));
		foreach (rows[r]) begin
			apb(rows[r].a, rows[r].w, rows[r].d);
			if (!rows[r].w) chk(rd, rows[r].d);
			chk(32'(err), 32'(rows[r].e));
		end
		rdchk(MD, 32'h1234);
		// Every edge selection on a capture channel, rising then falling.
		for (s = 0; s < 4; s++) begin
			apb(CF, 1'b1, 32'(s << 2));
			pin(0, 1'b1);
			rdchk(ST, 32'(s[0]) << 1);
			clr(32'h2);
			pin(0, 1'b0);
			rdchk(ST, 32'(s[1]) << 1);
			clr(32'h2);
		end
		rdchk(ST, 32'h0);
		// Unarmed zero, write of one, event between read and write, then a clean clear.
		apb(CF, 1'b1, 32'h4);
		apb(CF + 4, 1'b1, 32'h4);
		pin(0, 1'b1);
		apb(ST, 1'b1, 32'h0);
		rdchk(ST, 32'h2);
		apb(ST, 1'b1, 32'h2);
		rdchk(ST, 32'h2);
		pin(0, 1'b0);
		pin(0, 1'b1);
		apb(ST, 1'b1, 32'h0);
		rdchk(ST, 32'h2);
		apb(ST, 1'b1, 32'h0);
		rdchk(ST, 32'h0);
		// A read that armed channel 0 must not arm channel 1.
		pin(0, 1'b0);
		pin(0, 1'b1);
		rdchk(ST, 32'h2);
		pin(1, 1'b1);
		apb(ST, 1'b1, 32'h0);
		rdchk(ST, 32'h4);
		// Channel interrupt: raised, masked, unmasked, cleared.
		apb(CF + 4, 1'b1, 32'h14);
		repeat (2) @(posedge clock);
		chk(32'(irq), 32'h1);
		apb(MK, 1'b1, 32'h4);
		repeat (2) @(posedge clock);
		chk(32'(irq), 32'h0);
		apb(MK, 1'b1, 32'h0);
		repeat (2) @(posedge clock);
		chk(32'(irq), 32'h1);
		clr(32'h4);
		repeat (2) @(posedge clock);
		chk(32'(irq), 32'h0);
		// Up-counting with a modulus: compare, edge PWM and wrap.
		apb(CF, 1'b1, 32'(tef_pkg::MODE_COMPARE));
		apb(CF + 4, 1'b1, 32'(tef_pkg::MODE_EDGE_PWM));
		apb(CV, 1'b1, 32'h3);
		apb(CV + 4, 1'b1, 32'h5);
		apb(MD, 1'b1, 32'h7);
		apb(CT, 1'b1, 32'h5);
		waitFlag(1, 40);
		waitFlag(2, 40);
		waitFlag(0, 40);
		apb(CN, 1'b0, 32'h0);
		chk(32'(rd <= 32'h7), 32'h1);
		repeat (2) @(posedge clock);
		chk(32'(irq), 32'h1);
		apb(CT, 1'b1, 32'h0);
		repeat (2) @(posedge clock);
		chk(32'(irq), 32'h0);
		// Up/down counting: wrap at the turn, two matches each period.
		// The modulus stays at 7 so the stopped count can never sit above it.
		clr(32'h7);
		apb(MD, 1'b1, 32'h7);
		apb(CV, 1'b1, 32'h2);
		apb(CT, 1'b1, 32'h3);
		for (i = 0; i < 6; i++) begin
			apb(CN, 1'b0, 32'h0);
			chk(32'(rd <= 32'h7), 32'h1);
		end
		waitFlag(0, 40);
		waitFlag(1, 40);
		clr(32'h2);
		waitFlag(1, 12);
		// Free-running full range.
		apb(CT, 1'b1, 32'h0);
		apb(MD, 1'b1, 32'h0);
		clr(32'h7);
		apb(CT, 1'b1, 32'h1);
		apb(ST, 1'b0, 32'h0);
		chk(32'(rd[0]), 32'h0);
		waitFlag(0, 25000);
		complete_run();
	end
endmodule
